// ==== design/timeout_guard.sv ====
// timeout guard: mode control, timed unlock, period select and expiry actions
// assumes the core gives restart and vector-taken pulses and a free oscillator level
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timeout_guard_cfg.svh"

// Operation
// RQ1 - interrupt request needs enable and global enable
// RQ2 - interrupt-only mode interrupts, never resets
// RQ3 - mode decode: stopped, interrupt, reset, interrupt-then-reset
// RQ4 - fuse programmed forces reset mode
// RQ5 - combined mode: first expiry sets flag
// RQ6 - vector taken clears enable and flag
// RQ7 - combined mode: unserviced second expiry resets
// RQ8 - software re-arms interrupt enable after each interrupt
// RQ9 - clearing reset enable or select needs unlock
// RQ10 - unlock self-clears after four clocks
// RQ11 - cause flag holds reset enable set
// RQ12 - software clears cause flag before reset enable
// RQ13 - select maps to 2048 cycles doubling per code
// RQ14 - periods span 16 ms to 8 s
// RQ15 - guard reset goes to vector zero
// RQ16 - unlock write then new values within four clocks
// RQ17 - writing one clears the interrupt flag
// RQ18 - cause flag set by guard reset, cleared by zero
// RQ19 - count cycles of the separate slow oscillator
// RQ20 - restart or select change zeroes the counter
// RQ21 - oscillator passes a synchroniser before counting
module timeout_guard #(
    parameter int BASE_CYCLES = `TG_BASE_CYCLES,
    parameter int CNT_W = 21
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // core side
    input wire logic restart_req,
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    input wire logic always_on_fuse_n,
    input wire logic osc_clk_in,
    output logic irq_req,
    output logic sys_reset_req,
    output logic [15:0] reset_vector
);

    // control state
    logic timeout_irq_flag;
    logic timeout_irq_enable;
    logic timeout_reset_enable;
    logic change_unlock;
    logic [2:0] unlock_cnt;
    logic [3:0] timeout_select;
    logic watchdog_reset_cause_flag;
    logic next_timeout_irq_flag;
    logic next_timeout_irq_enable;
    logic next_timeout_reset_enable;
    logic next_change_unlock;
    logic [2:0] next_unlock_cnt;
    logic [3:0] next_timeout_select;
    logic next_watchdog_reset_cause_flag;
    logic next_irq_req;
    logic next_sys_reset_req;

    // bus state
    logic [31:0] next_readdata;
    logic next_waitrequest;

    // counter state
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // decoded terms
    logic fuse_on;
    logic re_eff;
    logic ie_eff;
    logic [3:0] sel_eff;
    logic [CNT_W-1:0] period;
    logic tick;
    logic expiry;
    logic ctrl_wr;
    logic cause_wr;
    logic [7:0] wd;
    logic [7:0] ctrl_rdval;
    timeout_guard_pkg::guard_mode_e mode;

    always_comb begin
        fuse_on = !always_on_fuse_n;
        re_eff = timeout_reset_enable | watchdog_reset_cause_flag | fuse_on; // RQ4 RQ11
        ie_eff = timeout_irq_enable & !fuse_on; // RQ4
        unique case ({re_eff, ie_eff}) // RQ3
            2'b00: mode = timeout_guard_pkg::mode_stopped;
            2'b01: mode = timeout_guard_pkg::mode_irq;
            2'b10: mode = timeout_guard_pkg::mode_reset;
            2'b11: mode = timeout_guard_pkg::mode_irq_reset;
        endcase
        // reserved select codes run at the longest period
        sel_eff = (timeout_select > `TG_SEL_MAX) ? `TG_SEL_MAX : timeout_select;
        period = CNT_W'(BASE_CYCLES) << sel_eff; // RQ13 RQ14
        tick = osc_s2 & !osc_prev; // RQ19
        expiry = (mode != timeout_guard_pkg::mode_stopped) && tick && !restart_req
            && (cnt == period - CNT_W'(1));
        wd = writedata[7:0];
        ctrl_wr = write && !waitrequest && (address == `TG_CTRL_OFS) && byteenable[0];
        cause_wr = write && !waitrequest && (address == `TG_CAUSE_OFS) && byteenable[0];
        ctrl_rdval = {timeout_irq_flag, ie_eff, timeout_select[3], change_unlock,
            re_eff, timeout_select[2:0]}; // RQ11
    end

    // bus: waitrequest drops for one cycle after a request is seen
    always_comb begin
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata = readdata;
        if (read && waitrequest) begin
            unique case (address)
                `TG_CTRL_OFS: next_readdata = {24'h000000, ctrl_rdval};
                `TG_CAUSE_OFS: next_readdata = {28'h0000000, watchdog_reset_cause_flag, 3'h0};
                default: next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
        end
    end

    // control register, flags and expiry actions
    always_comb begin
        next_timeout_irq_flag = timeout_irq_flag;
        next_timeout_irq_enable = timeout_irq_enable;
        next_timeout_reset_enable = timeout_reset_enable;
        next_change_unlock = change_unlock;
        next_unlock_cnt = unlock_cnt;
        next_timeout_select = timeout_select;
        next_watchdog_reset_cause_flag = watchdog_reset_cause_flag;
        next_sys_reset_req = 1'b0;
        if (change_unlock) begin
            next_unlock_cnt = unlock_cnt - 3'h1;
            if (unlock_cnt == 3'h1) begin
                next_change_unlock = 1'b0; // RQ10
            end
        end
        if (ctrl_wr) begin
            if (wd[`TG_FLAG_BIT]) begin
                next_timeout_irq_flag = 1'b0; // RQ17
            end
            next_timeout_irq_enable = wd[`TG_IE_BIT];
            // a second unlock write inside the window does not stretch it
            if (wd[`TG_UNLOCK_BIT] && wd[`TG_RE_BIT] && !change_unlock) begin
                next_change_unlock = 1'b1; // RQ16
                next_unlock_cnt = `TG_UNLOCK_CYCLES; // RQ10
            end
            if (wd[`TG_RE_BIT]) begin
                next_timeout_reset_enable = 1'b1;
            end else if (change_unlock) begin
                next_timeout_reset_enable = 1'b0; // RQ9
            end
            if (change_unlock) begin
                next_timeout_select = {wd[`TG_SEL3_BIT], wd[2:0]}; // RQ9
            end
        end
        if (vector_ack) begin
            next_timeout_irq_enable = 1'b0; // RQ6
            next_timeout_irq_flag = 1'b0; // RQ6
        end
        if (cause_wr && !wd[`TG_CAUSE_BIT]) begin
            next_watchdog_reset_cause_flag = 1'b0; // RQ18
        end
        if (fuse_on) begin
            next_timeout_irq_enable = 1'b0; // RQ4
        end
        if (expiry) begin
            if (!re_eff || (ie_eff && !timeout_irq_flag)) begin
                next_timeout_irq_flag = 1'b1; // RQ2 RQ5
            end else begin
                // guard reset: reset mode, or flag still pending in combined mode
                next_sys_reset_req = 1'b1; // RQ4 RQ7
                next_watchdog_reset_cause_flag = 1'b1; // RQ18
                next_timeout_irq_flag = 1'b0;
                next_timeout_irq_enable = 1'b0;
                next_timeout_reset_enable = 1'b0;
                next_timeout_select = `TG_SEL_RESET;
            end
        end
        next_irq_req = timeout_irq_flag & ie_eff & global_irq_enable; // RQ1
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            timeout_irq_flag <= 1'b0;
            timeout_irq_enable <= 1'b0;
            timeout_reset_enable <= 1'b0;
            change_unlock <= 1'b0;
            unlock_cnt <= 3'h0;
            timeout_select <= `TG_SEL_RESET;
            watchdog_reset_cause_flag <= 1'b0;
            irq_req <= 1'b0;
            sys_reset_req <= 1'b0;
            reset_vector <= `TG_RESET_VECTOR;
        end else begin
            timeout_irq_flag <= next_timeout_irq_flag;
            timeout_irq_enable <= next_timeout_irq_enable;
            timeout_reset_enable <= next_timeout_reset_enable;
            change_unlock <= next_change_unlock;
            unlock_cnt <= next_unlock_cnt;
            timeout_select <= next_timeout_select;
            watchdog_reset_cause_flag <= next_watchdog_reset_cause_flag;
            irq_req <= next_irq_req;
            sys_reset_req <= next_sys_reset_req;
            reset_vector <= `TG_RESET_VECTOR; // RQ15
        end
    end

    // oscillator synchroniser and period counter
    always_comb begin
        next_cnt = cnt;
        if ((mode == timeout_guard_pkg::mode_stopped) || restart_req || next_sys_reset_req
            || (next_timeout_select != timeout_select)) begin
            next_cnt = '0; // RQ20
        end else if (tick) begin
            next_cnt = expiry ? '0 : cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_prev <= 1'b0;
            cnt <= '0;
        end else begin
            osc_s1 <= osc_clk_in; // RQ21
            osc_s2 <= osc_s1;
            osc_prev <= osc_s2;
            cnt <= next_cnt;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_irq_gate: assert property (irq_req |-> $past(global_irq_enable) && $past(ie_eff)) // RQ1
        else $error("interrupt raised without both enables");
    a_irq_only: assert property (expiry && !re_eff && ie_eff |=> timeout_irq_flag && !sys_reset_req) // RQ2
        else $error("interrupt-only mode did not flag or reset wrongly");
    a_stopped_mode: assert property (!re_eff && !ie_eff |=> !sys_reset_req && cnt == '0) // RQ3
        else $error("stopped guard acted");
    a_fuse_reset: assert property (expiry && fuse_on |=> sys_reset_req && !timeout_irq_enable) // RQ4
        else $error("fuse did not force reset mode");
    a_first_flag: assert property (expiry && re_eff && ie_eff && !timeout_irq_flag
        |=> timeout_irq_flag && !sys_reset_req) // RQ5
        else $error("combined mode first expiry wrong");
    a_vector_clear: assert property (vector_ack && !expiry |=> !timeout_irq_enable && !timeout_irq_flag) // RQ6
        else $error("vector did not clear enable and flag");
    a_second_reset: assert property (expiry && re_eff && timeout_irq_flag |=> sys_reset_req) // RQ7
        else $error("pending flag at expiry did not reset");
    a_locked_select: assert property (ctrl_wr && !change_unlock && !expiry |=> $stable(timeout_select)) // RQ9
        else $error("select changed while locked");
    a_unlock_window: assert property ($rose(change_unlock) |-> change_unlock[*4] ##1 !change_unlock) // RQ10
        else $error("unlock window not four cycles");
    a_cause_forces: assert property (watchdog_reset_cause_flag |-> ctrl_rdval[`TG_RE_BIT] && re_eff) // RQ11
        else $error("cause flag does not hold reset enable");
    a_flag_w1c: assert property (ctrl_wr && wd[`TG_FLAG_BIT] && !expiry |=> !timeout_irq_flag) // RQ17
        else $error("flag not cleared by writing one");
    a_cause_set: assert property (sys_reset_req |-> watchdog_reset_cause_flag) // RQ18
        else $error("guard reset without cause flag");
    a_restart_zero: assert property (restart_req |=> cnt == '0) // RQ20
        else $error("restart did not zero the counter");

endmodule : timeout_guard
`default_nettype wire

// ==== pkg/timeout_guard_cfg.svh ====
// offsets, field positions, reset values and timing counts of the timeout guard
// assumes a byte-addressed register bus with one 32-bit word per register
`ifndef TIMEOUT_GUARD_CFG_SVH
`define TIMEOUT_GUARD_CFG_SVH

`define TG_CTRL_OFS 4'h0
`define TG_CAUSE_OFS 4'h4

`define TG_FLAG_BIT 7
`define TG_IE_BIT 6
`define TG_SEL3_BIT 5
`define TG_UNLOCK_BIT 4
`define TG_RE_BIT 3
`define TG_CAUSE_BIT 3

`define TG_CTRL_RESET 8'h00
`define TG_SEL_RESET 4'h0
`define TG_SEL_MAX 4'h9
`define TG_UNLOCK_CYCLES 3'h4
`define TG_RESET_VECTOR 16'h0000

`define TG_OSC_HZ 128000
`define TG_SHORT_MS 16
`define TG_BASE_CYCLES (`TG_OSC_HZ * `TG_SHORT_MS / 1000)

`endif

// ==== pkg/timeout_guard_pkg.sv ====
// types shared by the timeout guard
// assumes nothing of its surroundings
`default_nettype none
package timeout_guard_pkg;

    typedef enum logic [1:0] {
        mode_stopped,
        mode_irq,
        mode_reset,
        mode_irq_reset
    } guard_mode_e;

endpackage : timeout_guard_pkg
`default_nettype wire

// ==== sim/core_model.sv ====
// core model: slow oscillator level and a vector-taken pulse after a set delay
// assumes one sys_clk domain and a registered irq_req from the guard
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // guard side
    input wire logic irq_req,
    output logic osc_clk_in,
    output logic vector_ack,
    // scenario control
    input wire logic ack_en,
    input wire logic [3:0] ack_dly
);
    logic [2:0] div = 3'h0;
    logic [3:0] wt = 4'h0;
    logic busy = 1'b0;
    logic ack_d = 1'b0;
    initial vector_ack = 1'b0;
    // divide by eight so the guard always sees every edge
    assign osc_clk_in = div[2];
    always @(posedge sys_clk) begin
        div <= div + 3'h1;
        vector_ack <= 1'b0;
        ack_d <= vector_ack;
        if (srst) begin
            busy <= 1'b0;
        end else if (busy) begin
            wt <= wt - 4'h1;
            if (wt == 4'h0) begin
                vector_ack <= 1'b1;
                busy <= 1'b0;
            end
        // irq_req lags the clear by two edges, so skip two cycles after a pulse
        end else if (irq_req && ack_en && !vector_ack && !ack_d) begin
            busy <= 1'b1;
            wt <= ack_dly;
        end
    end
endmodule : core_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// bench for the timeout guard: register bus master, core model, scenario tasks
// assumes a shortened base period of 4 oscillator cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic restart_req = 1'b1;
    logic gie = 1'b0;
    logic fuse_n = 1'b1;
    logic ack_en = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] readdata;
    logic waitrequest, osc, vack, irq_req, sys_reset_req;
    logic [15:0] reset_vector;
    int n_fail = 0;
    int check_count = 0;
    int rst_cnt = 0;
    int irq_cnt = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        rst_cnt += int'(sys_reset_req === 1'b1);
        irq_cnt += int'(irq_req === 1'b1);
    end
    timeout_guard #(.BASE_CYCLES(4)) dut (.sys_clk(sys_clk), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .restart_req(restart_req),
        .global_irq_enable(gie), .vector_ack(vack), .always_on_fuse_n(fuse_n),
        .osc_clk_in(osc), .irq_req(irq_req), .sys_reset_req(sys_reset_req),
        .reset_vector(reset_vector));
    core_model partner (.sys_clk(sys_clk), .srst(srst), .irq_req(irq_req), .osc_clk_in(osc),
        .vector_ack(vack), .ack_en(ack_en), .ack_dly(dly));
    task close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int i;
        i = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do begin
            @(posedge sys_clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (i >= 50) begin
            chk(i, 0);
            close_out;
        end
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rd
    task automatic wait_for(input bit on_ack, input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((on_ack ? vack : sys_reset_req) !== 1'b1 && n < lim);
        if ((on_ack ? vack : sys_reset_req) !== 1'b1) begin
            chk(n, 0);
            close_out;
        end
    endtask : wait_for
    task t_reset;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        chk(reset_vector, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_irq_only;
        int n, m;
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h43);
        restart_req <= 1'b0;
        n = irq_cnt;
        m = rst_cnt;
        repeat (300) @(posedge sys_clk);
        rd(4'h0, 8'hc3);
        chk(irq_cnt - n, 0);
        chk(rst_cnt - m, 0);
        gie <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(irq_req, 1);
        wr(4'h0, 8'hc3);
        rd(4'h0, 8'h43);
        wr(4'h0, 8'h03);
        repeat (300) @(posedge sys_clk);
        rd(4'h0, 8'h03);
        chk(rst_cnt - m, 0);
        $display("interrupt mode test done");
    endtask : t_irq_only
    task automatic t_combined;
        int n, m, a;
        m = rst_cnt;
        ack_en <= 1'b1;
        wr(4'h0, 8'h4b);
        wait_for(1'b1, 400, n);
        rd(4'h0, 8'h0b);
        // re-arm each time to stay in combined mode
        wr(4'h0, 8'h4b);
        dly <= 4'h5;
        wait_for(1'b1, 400, n);
        chk(rst_cnt - m, 0);
        wr(4'h0, 8'h4b);
        ack_en <= 1'b0;
        a = irq_cnt;
        wait_for(1'b0, 700, n);
        chk(irq_cnt > a, 1);
        restart_req <= 1'b1;
        rd(4'h4, 8'h08);
        rd(4'h0, 8'h08);
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h00);
        $display("combined mode test done");
    endtask : t_combined
    task t_unlock;
        wr(4'h0, 8'h08);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08);
        wr(4'h0, 8'h18);
        repeat (6) @(posedge sys_clk);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08);
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h05);
        rd(4'h0, 8'h05);
        $display("unlock test done");
    endtask : t_unlock
    task automatic t_fuse;
        int n;
        fuse_n <= 1'b0;
        wr(4'h0, 8'h40);
        rd(4'h0, 8'h0d);
        restart_req <= 1'b0;
        wait_for(1'b0, 1200, n);
        restart_req <= 1'b1;
        fuse_n <= 1'b1;
        wr(4'h4, 8'h00);
        $display("fuse test done");
    endtask : t_fuse
    task automatic t_period;
        logic [3:0] tab [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
        logic [3:0] s;
        int n, m, p;
        for (int i = 0; i < 4; i++) begin
            s = tab[i];
            p = 32 << s;
            wr(4'h0, 8'h18);
            wr(4'h0, {2'b00, s[3], 2'b01, s[2:0]});
            m = rst_cnt;
            repeat (40) @(posedge sys_clk);
            chk(rst_cnt - m, 0);
            restart_req <= 1'b0;
            wait_for(1'b0, 20000, n);
            restart_req <= 1'b1;
            // slack covers oscillator phase and synchroniser delay
            chk(n > p - 10 && n < p + 12, 1);
            wr(4'h4, 8'h00);
        end
        $display("period test done");
    endtask : t_period
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset;
        t_irq_only;
        t_combined;
        t_unlock;
        t_fuse;
        t_period;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
